// ### verilog/pmc_pkg.sv
// Purpose: Constants for the privilege and operating-mode controller.
// Assumes: 32-bit state word, APB register access.
// Notes:   Offsets are byte addresses.
package pmc_pkg;
  localparam int          PSW_W        = 32;
  localparam int          USER_BIT     = 0;
  localparam int          DEBUG_BIT    = 12;
  localparam logic [31:0] PSW_RST      = 32'h0000_0000;
  localparam logic [31:0] PSW_WMASK    = 32'h0000_1327;
  // Register classes presented by the core for a control access
  localparam logic [1:0]  CLS_OS       = 2'h0;
  localparam logic [1:0]  CLS_DEBUG    = 2'h1;
  localparam logic [1:0]  CLS_PROG     = 2'h2;
  localparam logic [1:0]  CLS_OPEN     = 2'h3;
  // Shared debug register policy levels
  localparam logic [1:0]  POL_ANY      = 2'h0;
  localparam logic [1:0]  POL_PRIV     = 2'h1;
  localparam logic [1:0]  POL_DEBUG    = 2'h2;
  // APB register map
  localparam logic [7:0]  ADDR_PSW     = 8'h00;
  localparam logic [7:0]  ADDR_POLICY  = 8'h04;
  localparam logic [7:0]  ADDR_UPERM   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
  localparam logic [7:0]  ADDR_SHARED  = 8'h10;
  localparam logic [1:0]  POLICY_RST   = 2'h2;

  typedef enum logic [1:0] {
    PMC_SUPER     = 2'b00,
    PMC_USER      = 2'b01,
    PMC_DBG_SUPER = 2'b10,
    PMC_DBG_USER  = 2'b11
  } pmc_state_t;
endpackage : pmc_pkg

// ### verilog/pmc_access_gate.sv
// Purpose: Combinational access decision for control and debug registers.
// Assumes: Mode bits come straight from the state word.
// Notes:   Pure logic; the caller registers the answer.
`timescale 1ns/1ps
module pmc_access_gate
  import pmc_pkg::*;
(
  input  wire logic       debug_in,   // Debug flag
  input  wire logic       user_in,    // Unprivileged flag
  input  wire logic [1:0] class_in,   // Register class
  input  wire logic       uperm_in,   // User permission granted
  input  wire logic [1:0] policy_in,  // Shared debug policy
  output logic            ctrl_ok_out, // Control access allowed
  output logic            dsr_ok_out   // Shared debug access allowed
);
  always_comb
  begin
    ctrl_ok_out = 1'b0;
    if (debug_in)
      ctrl_ok_out = 1'b1;
    else
      case (class_in)
        CLS_DEBUG: ctrl_ok_out = 1'b0;
        CLS_OS:    ctrl_ok_out = !user_in;
        CLS_PROG:  ctrl_ok_out = !user_in || uperm_in;
        default:   ctrl_ok_out = 1'b1;
      endcase
  end

  always_comb
  begin
    case (policy_in)
      POL_ANY:   dsr_ok_out = 1'b1;
      POL_PRIV:  dsr_ok_out = debug_in || !user_in;
      default:   dsr_ok_out = debug_in;
    endcase
  end
endmodule : pmc_access_gate

// ### verilog/pmc_mode_ctrl.sv
// Purpose: Privilege and operating-mode controller with APB registers.
// Assumes: Trap and update strobes are one-cycle pulses from the pipeline.
// Notes:   Priority per cycle: debug trap, ordinary trap, state-word update.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pmc_mode_ctrl
  import pmc_pkg::*;
(
  input  wire logic             core_clk_in,    // 50 MHz core clock
  input  wire logic             reset_in,       // Async reset, active high
  // Pipeline events
  input  wire logic             trap_in,        // Ordinary trap taken
  input  wire logic             dbg_trap_in,    // Debug trap request
  input  wire logic             dbg_exc_in,     // Debug exception request
  input  wire logic             upd_in,         // Masked state-word update
  input  wire logic             rfi_in,         // Trap return
  input  wire logic [31:0]      upd_mask_in,    // Bits to modify
  input  wire logic [31:0]      upd_val_in,     // New values / restored word
  // Control register access check
  input  wire logic             creg_req_in,    // Control access request
  input  wire logic [1:0]       creg_class_in,  // Class of target register
  input  wire logic             dsr_req_in,     // Shared debug access (core)
  input  wire logic             dsr_ext_in,     // Access from another initiator
  // APB slave
  input  wire logic             psel_in,        // APB select
  input  wire logic             penable_in,     // APB enable
  input  wire logic             pwrite_in,      // APB write
  input  wire logic [7:0]       paddr_in,       // APB byte address
  input  wire logic [31:0]      pwdata_in,      // APB write data
  output logic                  pready_out,     // APB ready
  output logic                  pslverr_out,    // APB error
  output logic [31:0]           prdata_out,     // APB read data
  // Results
  output logic [PSW_W-1:0]      psw_out,        // Processor state word
  output logic [31:0]           old_psw_out,    // Word before last update
  output logic                  page_user_out,  // Use user page permissions
  output logic                  ill_inst_out,   // Illegal instruction trap
  output logic                  dbg_entry_out,  // Debug mode entered or debug exception raised
  output logic                  creg_ok_out,    // Control access granted
  output logic                  creg_err_out,   // Control access refused
  output logic                  dsr_ok_out      // Shared debug access granted
);
  import pmc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [PSW_W-1:0] processor_state_word;
  logic [PSW_W-1:0] next_psw;
  logic             dbg_pend;
  logic [1:0]       policy;
  logic             uperm;
  logic [31:0]      shared_reg;
  logic             in_debug;
  logic             is_user;
  logic             upd_any;
  logic             take_dbg;
  logic             gate_ctrl_ok;
  logic             gate_dsr_ok;
  pmc_state_t       state;

  assign in_debug = processor_state_word[DEBUG_BIT];
  assign is_user  = processor_state_word[USER_BIT] && !in_debug;
  assign state    = pmc_state_t'({processor_state_word[DEBUG_BIT], processor_state_word[USER_BIT]});
  assign upd_any  = (upd_in || rfi_in) && !is_user;
  // Held request fires once debug mode has been left
  assign take_dbg = !in_debug && (dbg_trap_in || dbg_pend);

  // ----------------------------------------
  // Next state word
  // ----------------------------------------
  always_comb
  begin
    next_psw = processor_state_word;
    if (take_dbg)
    begin
      next_psw[DEBUG_BIT] = 1'b1;
      next_psw[USER_BIT]  = 1'b0;
    end
    else if (trap_in)
    begin
      // Debug flag untouched, so a trap in debug stays in debug
      next_psw[USER_BIT] = 1'b0;
    end
    else if (upd_any)
    begin
      next_psw = (processor_state_word & ~upd_mask_in) | (upd_val_in & upd_mask_in);
      if (rfi_in)
        next_psw = upd_val_in;
      next_psw = next_psw & PSW_WMASK;
      // Supervisor may not enter debug through an update
      if (!in_debug)
        next_psw[DEBUG_BIT] = 1'b0;
      // Debug-supervisor setting the flag goes debug-user
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      processor_state_word <= PSW_RST;
    else
      processor_state_word <= next_psw;
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      old_psw_out <= 32'h0000_0000;
    else if (upd_any && !take_dbg && !trap_in)
      old_psw_out <= processor_state_word;
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      dbg_pend <= 1'b0;
    else if (take_dbg)
      dbg_pend <= 1'b0;
    else if (in_debug && dbg_trap_in)
      dbg_pend <= 1'b1;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      psw_out       <= PSW_RST;
      page_user_out <= 1'b0;
      ill_inst_out  <= 1'b0;
      dbg_entry_out <= 1'b0;
    end
    else
    begin
      psw_out       <= next_psw;
      page_user_out <= next_psw[USER_BIT];
      ill_inst_out  <= (upd_in || rfi_in) && is_user;
      // Debug exceptions are dropped while in debug mode
      dbg_entry_out <= take_dbg || (dbg_exc_in && !in_debug);
    end
  end

  pmc_access_gate u_gate (
    .debug_in    (in_debug),
    .user_in     (processor_state_word[USER_BIT]),
    .class_in    (creg_class_in),
    .uperm_in    (uperm),
    .policy_in   (policy),
    .ctrl_ok_out (gate_ctrl_ok),
    .dsr_ok_out  (gate_dsr_ok)
  );

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      creg_ok_out  <= 1'b0;
      creg_err_out <= 1'b0;
      dsr_ok_out   <= 1'b0;
    end
    else
    begin
      creg_ok_out  <= creg_req_in && gate_ctrl_ok;
      creg_err_out <= creg_req_in && !gate_ctrl_ok;
      // Other initiators are not subject to the core's mode
      dsr_ok_out   <= dsr_ext_in || (dsr_req_in && gate_dsr_ok);
    end
  end

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  logic apb_setup;
  logic apb_access;
  logic priv_wr;
  logic known;
  assign apb_setup  = psel_in && !penable_in;
  // Writes land only on the completing edge, never in the setup cycle
  assign apb_access = psel_in && penable_in && pready_out;
  // Permission registers only change from supervisor or debug
  assign priv_wr   = apb_access && pwrite_in && !is_user;
  assign known     = paddr_in == ADDR_PSW || paddr_in == ADDR_POLICY ||
                     paddr_in == ADDR_UPERM || paddr_in == ADDR_STATUS ||
                     paddr_in == ADDR_SHARED;

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      policy     <= POLICY_RST;
      uperm      <= 1'b0;
      shared_reg <= 32'h0000_0000;
    end
    else
    begin
      if (priv_wr && paddr_in == ADDR_POLICY)
        policy <= pwdata_in[1:0];
      if (priv_wr && paddr_in == ADDR_UPERM)
        uperm <= pwdata_in[0];
      if (apb_access && pwrite_in && paddr_in == ADDR_SHARED && gate_dsr_ok)
        shared_reg <= pwdata_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= apb_setup;
      pslverr_out <= apb_setup && (!known || (pwrite_in && is_user &&
                     (paddr_in == ADDR_POLICY || paddr_in == ADDR_UPERM)));
      prdata_out  <= 32'h0000_0000;
      if (apb_setup && !pwrite_in)
        case (paddr_in)
          ADDR_PSW:    prdata_out <= processor_state_word;
          ADDR_POLICY: prdata_out <= {30'h0, policy};
          ADDR_UPERM:  prdata_out <= {31'h0, uperm};
          ADDR_STATUS: prdata_out <= {29'h0, dbg_pend, state};
          ADDR_SHARED: prdata_out <= gate_dsr_ok ? shared_reg : 32'h0000_0000;
          default:     prdata_out <= 32'h0000_0000;
        endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_debug_entry_clears: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    take_dbg |=> processor_state_word[DEBUG_BIT] && !processor_state_word[USER_BIT])
    else $error("debug entry left user flag set");
  chk_no_sneak_debug: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !in_debug && !take_dbg |=> !processor_state_word[DEBUG_BIT])
    else $error("debug mode entered without debug trap");
  chk_super_update_ignored: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !in_debug && upd_in && !trap_in && !take_dbg |=> !processor_state_word[DEBUG_BIT])
    else $error("supervisor set debug flag");
  chk_user_illegal: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    is_user && (upd_in || rfi_in) && !trap_in && !take_dbg |=> ill_inst_out && $stable(processor_state_word))
    else $error("user update not trapped");
  chk_trap_supervisor: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    trap_in && !take_dbg |=> !processor_state_word[USER_BIT] && processor_state_word[DEBUG_BIT] == $past(in_debug))
    else $error("trap changed mode wrongly");
  chk_pending_reentry: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    dbg_pend && !in_debug |=> processor_state_word[DEBUG_BIT])
    else $error("pending debug interrupt lost");
  chk_debug_reg_guard: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    creg_req_in && creg_class_in == CLS_DEBUG && !in_debug |=> creg_err_out)
    else $error("debug register reached outside debug");
  chk_page_select: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    ##1 page_user_out == processor_state_word[USER_BIT])
    else $error("page permission select wrong");
  chk_user_os_refused: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    creg_req_in && creg_class_in == CLS_OS && state == PMC_USER |=> !creg_ok_out)
    else $error("user reached OS register");
  chk_apb_answer: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    psel_in && !penable_in |=> pready_out)
    else $error("APB not answered");
  // Held debug requests must not surface while the debugger owns the core
  chk_debug_exc_quiet: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    in_debug |=> !dbg_entry_out)
    else $error("debug event raised in debug mode");
  chk_shared_write: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    apb_access && pwrite_in && paddr_in == ADDR_SHARED && gate_dsr_ok
    |=> shared_reg == $past(pwdata_in))
    else $error("shared debug register write lost");

  cov_debug_entry: cover property (@(posedge core_clk_in) disable iff (reset_in)
    state == PMC_USER ##1 take_dbg ##1 state == PMC_DBG_SUPER);
  cov_debug_user: cover property (@(posedge core_clk_in) disable iff (reset_in)
    state == PMC_DBG_SUPER ##1 state == PMC_DBG_USER);
  cov_reentry: cover property (@(posedge core_clk_in) disable iff (reset_in)
    dbg_pend && !in_debug);
  cov_user_trap: cover property (@(posedge core_clk_in) disable iff (reset_in)
    state == PMC_USER && trap_in);
endmodule : pmc_mode_ctrl

// ### testbench/pmc_trap_src.sv
// Purpose: Far-side model: trap sources and debug host event strobes.
// Assumes: One event per go pulse; kind 0 trap,1 dbg trap,2 dbg exc,3 update,4 return.
// Notes:   Strobes are one-cycle pulses launched on the edge after go.
`timescale 1ns/1ps
module pmc_trap_src
(
  input  wire logic       core_clk_in,  // Core clock
  input  wire logic       reset_in,     // Async reset
  input  wire logic       go_in,        // Launch one event
  input  wire logic [2:0] kind_in,      // Event kind
  output logic            trap_out,     // Ordinary trap
  output logic            dbg_trap_out, // Debug trap request
  output logic            dbg_exc_out,  // Debug exception
  output logic            upd_out,      // Masked update
  output logic            rfi_out       // Trap return
);
  // Pulses only; a held debug request would hide the pending path
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      {trap_out, dbg_trap_out, dbg_exc_out, upd_out, rfi_out} <= 5'h00;
    end
    else
    begin
      trap_out     <= go_in && kind_in == 3'h0;
      dbg_trap_out <= go_in && kind_in == 3'h1;
      dbg_exc_out  <= go_in && kind_in == 3'h2;
      upd_out      <= go_in && kind_in == 3'h3;
      rfi_out      <= go_in && kind_in == 3'h4;
    end
  end
endmodule : pmc_trap_src

// ### testbench/test_privilege_mode_control.sv
// Purpose: Self-checking bench for the mode controller.
// Assumes: APB answers in the access cycle; events answer one edge later.
// Notes:   Event outputs are sampled on the falling edge; APB answers at the rising edge.
`timescale 1ns/1ps
module test_privilege_mode_control;
  import pmc_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [31:0] mask = 32'h0;
  logic [31:0] val = 32'h0;
  logic creq = 1'b0;
  logic [1:0] ccls = 2'h0;
  logic dreq = 1'b0;
  logic dext = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic trap, dtrap, dexc, upd, rfi, pready, pslverr, page_user, ill, dent, cok, cerr, dok;
  logic [31:0] prdata, processor_state_word, old_psw;
  int fails = 0;
  int cmp_count = 0;
  always #10 core_clk_in = ~core_clk_in;
  pmc_trap_src src (.core_clk_in(core_clk_in), .reset_in(reset_in), .go_in(go),
    .kind_in(kind), .trap_out(trap), .dbg_trap_out(dtrap), .dbg_exc_out(dexc),
    .upd_out(upd), .rfi_out(rfi));
  pmc_mode_ctrl uut (.core_clk_in(core_clk_in), .reset_in(reset_in), .trap_in(trap),
    .dbg_trap_in(dtrap), .dbg_exc_in(dexc), .upd_in(upd), .rfi_in(rfi),
    .upd_mask_in(mask), .upd_val_in(val), .creg_req_in(creq), .creg_class_in(ccls),
    .dsr_req_in(dreq), .dsr_ext_in(dext), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .psw_out(processor_state_word), .old_psw_out(old_psw),
    .page_user_out(page_user), .ill_inst_out(ill), .dbg_entry_out(dent),
    .creg_ok_out(cok), .creg_err_out(cerr), .dsr_ok_out(dok));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic ev(input logic [2:0] k, input logic [31:0] m, input logic [31:0] v);
    @(posedge core_clk_in);
    kind <= k;
    mask <= m;
    val <= v;
    go <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
    @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask : ev
  task automatic acc(input logic [1:0] c, input logic ok);
    @(posedge core_clk_in);
    creq <= 1'b1;
    ccls <= c;
    @(posedge core_clk_in);
    creq <= 1'b0;
    @(negedge core_clk_in);
    cmp("creg_ok", {31'h0, ok}, {31'h0, cok});
    cmp("creg_err", {31'h0, !ok}, {31'h0, cerr});
  endtask : acc
  task automatic dsr(input logic ext, input logic ok);
    @(posedge core_clk_in);
    dreq <= !ext;
    dext <= ext;
    @(posedge core_clk_in);
    dreq <= 1'b0;
    dext <= 1'b0;
    @(negedge core_clk_in);
    cmp("dsr_ok", {31'h0, ok}, {31'h0, dok});
  endtask : dsr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] er, input logic ee);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    pen <= 1'b1;
    @(posedge core_clk_in);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge core_clk_in);
      n++;
    end
    cmp("pready", 32'h1, {31'h0, pready});
    if (!w)
      cmp("prdata", er, prdata);
    cmp("pslverr", {31'h0, ee}, {31'h0, pslverr});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    cmp("psw", PSW_RST, processor_state_word);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_POLICY, 32'h0, {30'h0, POLICY_RST}, 1'b0);
    dsr(1'b0, 1'b0);
  endtask : t_reset
  task automatic t_user();
    ev(3'h3, 32'h1, 32'h1);
    cmp("psw", 32'h1, processor_state_word);
    cmp("page_user", 32'h1, {31'h0, page_user});
    cmp("old_psw", 32'h0, old_psw);
    ev(3'h3, 32'h4, 32'h4);
    cmp("ill", 32'h1, {31'h0, ill});
    cmp("psw", 32'h1, processor_state_word);
    ev(3'h4, 32'h0, 32'h0);
    cmp("ill", 32'h1, {31'h0, ill});
    acc(CLS_OS, 1'b0);
    acc(CLS_DEBUG, 1'b0);
    acc(CLS_PROG, 1'b0);
    acc(CLS_OPEN, 1'b1);
    apb(1'b1, ADDR_UPERM, 32'h1, 32'h0, 1'b1);
    ev(3'h0, 32'h0, 32'h0);
    cmp("psw", 32'h0, processor_state_word);
    cmp("page_user", 32'h0, {31'h0, page_user});
  endtask : t_user
  task automatic t_super();
    ev(3'h3, 32'h1000, 32'h1000);
    cmp("psw", 32'h0, processor_state_word);
    cmp("ill", 32'h0, {31'h0, ill});
    cmp("dbg_entry", 32'h0, {31'h0, dent});
    acc(CLS_OS, 1'b1);
    acc(CLS_DEBUG, 1'b0);
    apb(1'b1, ADDR_UPERM, 32'h1, 32'h0, 1'b0);
    ev(3'h4, 32'h0, 32'h1);
    cmp("psw", 32'h1, processor_state_word);
    acc(CLS_PROG, 1'b1);
    ev(3'h0, 32'h0, 32'h0);
  endtask : t_super
  task automatic t_debug();
    int n;
    ev(3'h3, 32'h1, 32'h1);
    ev(3'h1, 32'h0, 32'h0);
    cmp("psw", 32'h1000, processor_state_word);
    cmp("dbg_entry", 32'h1, {31'h0, dent});
    acc(CLS_DEBUG, 1'b1);
    dsr(1'b0, 1'b1);
    ev(3'h0, 32'h0, 32'h0);
    cmp("psw", 32'h1000, processor_state_word);
    ev(3'h2, 32'h0, 32'h0);
    cmp("dbg_entry", 32'h0, {31'h0, dent});
    ev(3'h1, 32'h0, 32'h0);
    cmp("dbg_entry", 32'h0, {31'h0, dent});
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h6, 1'b0);
    ev(3'h3, 32'h1, 32'h1);
    cmp("psw", 32'h1001, processor_state_word);
    cmp("page_user", 32'h1, {31'h0, page_user});
    cmp("old_psw", 32'h1000, old_psw);
    apb(1'b0, ADDR_PSW, 32'h0, 32'h1001, 1'b0);
    ev(3'h3, 32'h1000, 32'h0);
    n = 0;
    while (dent !== 1'b1 && n < 4)
    begin
      @(negedge core_clk_in);
      n++;
    end
    cmp("reentry", 32'h1, {31'h0, dent});
    cmp("psw", 32'h1000, processor_state_word);
    ev(3'h3, 32'h1000, 32'h0);
    cmp("psw", 32'h0, processor_state_word);
  endtask : t_debug
  task automatic t_policy();
    for (int p = 0; p < 3; p++)
    begin
      apb(1'b1, ADDR_POLICY, p, 32'h0, 1'b0);
      dsr(1'b0, p != 2);
      dsr(1'b1, 1'b1);
      apb(1'b1, ADDR_SHARED, 32'h0000_5a00 + p, 32'h0, 1'b0);
      apb(1'b0, ADDR_SHARED, 32'h0, (p != 2) ? 32'h0000_5a00 + p : 32'h0, 1'b0);
    end
    apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
  endtask : t_policy
  initial
  begin
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(negedge core_clk_in);
    t_reset();
    t_user();
    t_super();
    t_debug();
    t_policy();
    end_sim();
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    #200000;
    fails++;
    end_sim();
  end
endmodule : test_privilege_mode_control
